// file: common/dma_regs_pkg.sv
// constants and types shared by the dma register set
package dma_regs_pkg;
	localparam int CHANNELS = 4;
	localparam int PORT_ADDR_W = 4;
	localparam int DATA_W = 8;
	localparam int WORD_W = 16;
	// port addresses, low nibble of the i/o address
	localparam logic [3:0] ADDR_WORD_LAST = 4'h7;
	localparam logic [3:0] ADDR_COMMAND_STATUS = 4'h8;
	localparam logic [3:0] ADDR_REQUEST = 4'h9;
	localparam logic [3:0] ADDR_SINGLE_MASK = 4'ha;
	localparam logic [3:0] ADDR_MODE = 4'hb;
	localparam logic [3:0] ADDR_BYTE_PTR = 4'hc;
	localparam logic [3:0] ADDR_MASTER_CLEAR = 4'hd;
	localparam logic [3:0] ADDR_CLEAR_MASK = 4'he;
	localparam logic [3:0] ADDR_ALL_MASK = 4'hf;
	// command register fields
	localparam int CMD_GRANT_POL = 7;
	localparam int CMD_REQ_POL = 6;
	localparam int CMD_EARLY_WRITE = 5;
	localparam int CMD_ROTATE = 4;
	localparam int CMD_COMPRESSED = 3;
	localparam int CMD_DISABLE = 2;
	localparam int CMD_ADDR_HOLD = 1;
	localparam int CMD_MEM_TO_MEM = 0;
	// mode register fields, then the request and mask value bit and the word port address bits
	localparam int MODE_XFER_HI = 7;
	localparam int MODE_XFER_LO = 6;
	localparam int MODE_DEC = 5;
	localparam int MODE_AUTO = 4;
	localparam int MODE_TYPE_HI = 3;
	localparam int MODE_TYPE_LO = 2;
	localparam int SEL_HI = 1;
	localparam int SEL_LO = 0;
	localparam int VALUE_BIT = 2;
	localparam int WORD_SEL_BIT = 0;
	localparam int WORD_CH_HI = 2;
	localparam int WORD_CH_LO = 1;
	// encodings
	localparam logic [1:0] XFER_DEMAND = 2'h0;
	localparam logic [1:0] XFER_SINGLE = 2'h1;
	localparam logic [1:0] XFER_BLOCK = 2'h2;
	localparam logic [1:0] XFER_CASCADE = 2'h3;
	localparam logic [1:0] TYPE_VERIFY = 2'h0;
	localparam logic [1:0] TYPE_WRITE = 2'h1;
	localparam logic [1:0] TYPE_READ = 2'h2;
	// reset and fixed values
	localparam logic [7:0] COMMAND_RESET = 8'h00;
	localparam logic [3:0] MASK_RESET = 4'hf;
	localparam logic [3:0] UPPER_ONES = 4'hf;
	localparam logic [1:0] SEL_READ_ONES = 2'h3;
	localparam logic [7:0] BYTE_ZERO = 8'h00;
	localparam logic [15:0] WORD_ZERO = 16'h0000;
	localparam logic [15:0] WORD_ONE = 16'h0001;
	typedef enum {st_idle, st_s2, st_s3, st_s3_wait, st_s4, st_cascade} cycle_state_t;
endpackage

// file: tb/dma_channel_register_set_tb.sv
// register level tests of the dma register set
`timescale 1ns/10ps
`define CHK(n, e, g) begin tests_run++; if ((g) !== (e)) begin \
	$display("ERROR %s exp %h got %h", n, e, g); bad_count++; end end
module dma_channel_register_set_tb;
	import dma_regs_pkg::*;
	logic clk_in = 1'b0;
	logic rst_in = 1'b1;
	logic [3:0] addr = 4'h0;
	logic rd = 1'b0;
	logic wr_s = 1'b0;
	logic [7:0] din = 8'h00;
	logic [7:0] dout;
	logic oe;
	logic [3:0] req;
	logic [3:0] grant;
	logic rcmd, wcmd, tc;
	logic [15:0] xaddr;
	logic p_load = 1'b0;
	logic [1:0] p_chan = 2'h0;
	logic [3:0] p_count = 4'h0;
	logic [7:0] mv [4] = '{8'h04, 8'h69, 8'h92, 8'hf7};
	int bad_count = 0;
	int tests_run = 0;
	int rd_cycles = 0;
	int wr_cycles = 0;
	always #5 clk_in = ~clk_in;
	// count clock cycles with each transfer command high
	always @(posedge clk_in) begin
		if (rcmd === 1'b1)
			rd_cycles++;
		if (wcmd === 1'b1)
			wr_cycles++;
	end
	dma_channel_register_set dma_channel_register_set_inst (.clk_in(clk_in), .rst_in(rst_in),
		.port_addr_in(addr), .io_read_strobe_in(rd), .io_write_strobe_in(wr_s),
		.peripheral_data_bus_in(din), .peripheral_data_bus_out(dout),
		.peripheral_data_bus_oe_out(oe), .channel_request_in(req), .channel_grant_out(grant),
		.read_command_out(rcmd), .write_command_out(wcmd), .terminal_count_out(tc),
		.transfer_address_out(xaddr));
	dma_peripheral_model dma_peripheral_model_inst (.clk_in(clk_in), .rst_in(rst_in),
		.load_in(p_load), .chan_in(p_chan), .count_in(p_count), .grant_in(grant),
		.request_out(req));
	// one strobe cycle per access
	task wr(input logic [3:0] a, input logic [7:0] d);
		@(posedge clk_in);
		addr <= a;
		din <= d;
		wr_s <= 1'b1;
		@(posedge clk_in);
		wr_s <= 1'b0;
	endtask
	task rdc(input logic [3:0] a, input logic [7:0] e, input logic [7:0] m);
		@(posedge clk_in);
		addr <= a;
		rd <= 1'b1;
		@(posedge clk_in);
		rd <= 1'b0;
		#1 `CHK($sformatf("port %h", a), e & m, dout & m)
	endtask
	task wword(input logic [3:0] a, input logic [15:0] w);
		wr(ADDR_BYTE_PTR, 8'hff);
		wr(a, w[7:0]);
		wr(a, w[15:8]);
	endtask
	task rword(input logic [3:0] a, input logic [15:0] w);
		wr(ADDR_BYTE_PTR, 8'h00);
		rdc(a, w[7:0], 8'hff);
		rdc(a, w[15:8], 8'hff);
	endtask
	task peer(input logic [1:0] c, input logic [3:0] n);
		@(posedge clk_in);
		p_chan <= c;
		p_count <= n;
		p_load <= 1'b1;
		@(posedge clk_in);
		p_load <= 1'b0;
	endtask
	task wait_tc;
		for (int i = 0; i < 300; i++) begin
			@(posedge clk_in);
			#1;
			if (tc === 1'b1)
				break;
		end
		`CHK("terminal count", 1'b1, tc)
		repeat (5) @(posedge clk_in);
	endtask
	task test_done;
		$display("checks %0d mismatches %0d", tests_run, bad_count);
		if (bad_count == 0 && tests_run > 0)
			$display("Testbench passed");
		else
			$display("Testbench failed");
		$finish;
	endtask
	// watchdog far beyond the expected run
	initial begin
		#200000;
		bad_count++;
		test_done;
	end
	// main sequence
	initial begin
		repeat (12) @(posedge clk_in);
		rst_in <= 1'b0;
		rdc(ADDR_SINGLE_MASK, 8'h00, 8'hff);
		rdc(ADDR_ALL_MASK, 8'h0f, 8'h0f);
		wr(ADDR_COMMAND_STATUS, 8'h84);
		rdc(ADDR_SINGLE_MASK, 8'h84, 8'hff);
		`CHK("grant high idle", 4'h0, grant)
		wr(ADDR_COMMAND_STATUS, 8'h04);
		repeat (3) @(posedge clk_in);
		`CHK("grant low idle", 4'hf, grant)
		for (int i = 3; i >= 0; i--)
			wr(ADDR_MODE, mv[i]);
		rdc(ADDR_CLEAR_MASK, 8'h00, 8'hff);
		for (int i = 0; i < 4; i++)
			rdc(ADDR_MODE, mv[i] | 8'h03, 8'hff);
		wr(ADDR_REQUEST, 8'h06);
		wr(ADDR_REQUEST, 8'h04);
		rdc(ADDR_REQUEST, 8'hf5, 8'hff);
		wr(ADDR_REQUEST, 8'h02);
		rdc(ADDR_REQUEST, 8'hf1, 8'hff);
		wr(ADDR_REQUEST, 8'h00);
		wr(ADDR_SINGLE_MASK, 8'h01);
		rdc(ADDR_ALL_MASK, 8'h0d, 8'h0f);
		wr(ADDR_SINGLE_MASK, 8'h05);
		rdc(ADDR_ALL_MASK, 8'h0f, 8'h0f);
		wr(ADDR_CLEAR_MASK, 8'hff);
		rdc(ADDR_ALL_MASK, 8'h00, 8'h0f);
		wr(ADDR_ALL_MASK, 8'h0a);
		rdc(ADDR_ALL_MASK, 8'h0a, 8'h0f);
		wword(4'h0, 16'h1234);
		wword(4'h1, 16'h0001);
		rword(4'h0, 16'h1234);
		rdc(ADDR_BYTE_PTR, 8'h00, 8'hff);
		rdc(4'h1, 8'h00, 8'hff);
		// transfers: disabled first, then two single cycles on channel 0
		wr(ADDR_CLEAR_MASK, 8'h00);
		wr(ADDR_MODE, 8'h44);
		wr(ADDR_MODE, 8'h55);
		wword(4'h2, 16'h0010);
		wword(4'h3, 16'h0000);
		peer(2'h0, 4'h2);
		repeat (20) @(posedge clk_in);
		`CHK("grant disabled", 4'hf, grant)
		wr(ADDR_COMMAND_STATUS, 8'h00);
		wait_tc;
		rdc(ADDR_COMMAND_STATUS, 8'h01, 8'hff);
		rdc(ADDR_COMMAND_STATUS, 8'h00, 8'hff);
		rdc(ADDR_ALL_MASK, 8'h01, 8'h0f);
		rword(4'h0, 16'h1236);
		rword(4'h1, 16'hffff);
		`CHK("transfer address", 16'h1236, xaddr)
		`CHK("read cycles", 6, rd_cycles)
		`CHK("write cycles", 4, wr_cycles)
		wr(ADDR_COMMAND_STATUS, 8'h20);
		peer(2'h1, 4'h1);
		wait_tc;
		rdc(ADDR_COMMAND_STATUS, 8'h02, 8'hff);
		rdc(ADDR_ALL_MASK, 8'h01, 8'h0f);
		rword(4'h2, 16'h0010);
		rword(4'h3, 16'h0000);
		`CHK("reload address", 16'h0010, xaddr)
		`CHK("read cycles", 9, rd_cycles)
		`CHK("write cycles", 7, wr_cycles)
		// masked request still shows as pending
		wr(ADDR_SINGLE_MASK, 8'h06);
		peer(2'h2, 4'h1);
		repeat (5) @(posedge clk_in);
		rdc(ADDR_COMMAND_STATUS, 8'h40, 8'hff);
		`CHK("grant masked", 4'hf, grant)
		peer(2'h2, 4'h0);
		// memory to memory through the temporary register
		wr(ADDR_COMMAND_STATUS, 8'h01);
		wr(ADDR_REQUEST, 8'h04);
		din <= 8'h5a;
		repeat (40) @(posedge clk_in);
		rdc(ADDR_MASTER_CLEAR, 8'h5a, 8'hff);
		`CHK("read cycles", 12, rd_cycles)
		`CHK("write cycles", 9, wr_cycles)
		wr(ADDR_MASTER_CLEAR, 8'h00);
		repeat (3) @(posedge clk_in);
		rdc(ADDR_MASTER_CLEAR, 8'h00, 8'hff);
		rdc(ADDR_SINGLE_MASK, 8'h00, 8'hff);
		rdc(ADDR_ALL_MASK, 8'h0f, 8'h0f);
		rdc(ADDR_REQUEST, 8'hf0, 8'hff);
		test_done;
	end
endmodule // dma_channel_register_set_tb

// file: tb/dma_peripheral_model.sv
// peripheral that asks for a set number of single transfers
`timescale 1ns/10ps
module dma_peripheral_model (
	input wire logic clk_in,
	input wire logic rst_in,
	input wire logic load_in,
	input wire logic [1:0] chan_in,
	input wire logic [3:0] count_in,
	input wire logic [3:0] grant_in,
	output logic [3:0] request_out
);
	logic [3:0] left;
	logic seen;
	// one transfer used up at each new active low grant
	always_ff @(posedge clk_in) begin
		seen <= !grant_in[chan_in];
		if (rst_in)
			left <= 4'h0;
		else if (load_in)
			left <= count_in;
		else if (!grant_in[chan_in] && !seen && left != 4'h0)
			left <= left - 4'h1;
	end
	// request held high until granted, dropped while granted
	assign request_out = (left != 4'h0 && grant_in[chan_in]) ? (4'h1 << chan_in) : 4'h0;
endmodule // dma_peripheral_model

// file: tb/dma_regs_checker_assertions.sv
// port assertions for the dma register set
`timescale 1ns/10ps
module dma_regs_checker (
	input wire logic clk_in,
	input wire logic rst_in,
	input wire logic [dma_regs_pkg::PORT_ADDR_W-1:0] port_addr_in,
	input wire logic io_read_strobe_in,
	input wire logic io_write_strobe_in,
	input wire logic [dma_regs_pkg::DATA_W-1:0] peripheral_data_bus_out,
	input wire logic peripheral_data_bus_oe_out,
	input wire logic [dma_regs_pkg::CHANNELS-1:0] channel_grant_out,
	input wire logic read_command_out,
	input wire logic write_command_out,
	input wire logic terminal_count_out
);
	import dma_regs_pkg::*;
	default clocking cb @(posedge clk_in); endclocking
	default disable iff (rst_in);
	// read answers one cycle after the strobe
	a_read_oe: assert property (io_read_strobe_in |=> peripheral_data_bus_oe_out)
		else $error("read gave no output enable");
	// outside reads the bus is driven only by the memory to memory write phase
	a_oe_idle: assert property (!io_read_strobe_in |=> !peripheral_data_bus_oe_out
		|| (write_command_out && !read_command_out)) else $error("output enable without read");
	a_req_upper: assert property (io_read_strobe_in && port_addr_in == ADDR_REQUEST
		|=> peripheral_data_bus_out[7:4] == 4'hf) else $error("request read upper bits");
	a_mode_low: assert property (io_read_strobe_in && port_addr_in == ADDR_MODE
		|=> peripheral_data_bus_out[1:0] == 2'h3) else $error("mode read low bits");
	a_special_zero: assert property (io_read_strobe_in && (port_addr_in == ADDR_BYTE_PTR
		|| port_addr_in == ADDR_CLEAR_MASK) |=> peripheral_data_bus_out == 8'h00)
		else $error("special command read data");
	// idle after reset and master clear
	a_reset_grant: assert property ($fell(rst_in) |-> channel_grant_out == 4'hf)
		else $error("grants not idle after reset");
	a_reset_cmds: assert property ($fell(rst_in) |-> !read_command_out && !write_command_out)
		else $error("commands after reset");
	a_clear_idle: assert property (io_write_strobe_in && port_addr_in == ADDR_MASTER_CLEAR
		|=> ##1 channel_grant_out == 4'hf && !read_command_out && !write_command_out)
		else $error("master clear left controller busy");
	a_tc_pulse: assert property ($rose(terminal_count_out) |=> !terminal_count_out)
		else $error("terminal count pulse too long");
endmodule // dma_regs_checker

bind dma_channel_register_set dma_regs_checker dma_regs_checker_inst (.clk_in, .rst_in,
	.port_addr_in, .io_read_strobe_in, .io_write_strobe_in, .peripheral_data_bus_out,
	.peripheral_data_bus_oe_out, .channel_grant_out, .read_command_out, .write_command_out,
	.terminal_count_out);

// file: verilog/channel_word_regs.sv
// base and current address and word count of one channel
`timescale 1ns/10ps
module channel_word_regs (
	input wire logic clk_in,
	input wire logic rst_in,
	input wire logic write_in,
	input wire logic count_sel_in,
	input wire logic high_byte_in,
	input wire logic [dma_regs_pkg::DATA_W-1:0] data_in,
	input wire logic step_in,
	input wire logic count_down_in,
	input wire logic hold_in,
	input wire logic reload_in,
	output logic [dma_regs_pkg::WORD_W-1:0] address_out,
	output logic [dma_regs_pkg::WORD_W-1:0] count_out,
	output logic terminal_out
);
	import dma_regs_pkg::*;

	logic [WORD_W-1:0] base_address;
	logic [WORD_W-1:0] base_count;
	logic [WORD_W-1:0] next_word;

	// byte merge of a cpu write into the selected word
	always_comb begin
		next_word = count_sel_in ? count_out : address_out;
		if (high_byte_in)
			next_word[15:8] = data_in;
		else
			next_word[7:0] = data_in;
	end

	// count rolls from zero to all ones on this step unless auto reload is set
	assign terminal_out = (count_out == WORD_ZERO);

	// base copies follow every cpu write of the current word
	always_ff @(posedge clk_in) begin
		if (rst_in) begin
			base_address <= WORD_ZERO;
			base_count <= WORD_ZERO;
		end else if (write_in) begin
			if (count_sel_in)
				base_count <= next_word;
			else
				base_address <= next_word;
		end
	end

	// current words: cpu load, step, or reload at terminal count
	always_ff @(posedge clk_in) begin
		if (rst_in) begin
			address_out <= WORD_ZERO;
			count_out <= WORD_ZERO;
		end else if (write_in) begin
			if (count_sel_in)
				count_out <= next_word;
			else
				address_out <= next_word;
		end else if (step_in) begin
			if (terminal_out && reload_in) begin
				address_out <= base_address;
				count_out <= base_count;
			end else begin
				count_out <= count_out - WORD_ONE;
				if (!hold_in)
					address_out <= count_down_in ? address_out - WORD_ONE
						: address_out + WORD_ONE;
			end
		end
	end
endmodule // channel_word_regs

// file: verilog/dma_channel_register_set.sv
// four channel dma register set with a small transfer sequencer
// Behaviour
// - cpu write of current address or count also loads the base copy
// - terminal count with auto reload copies base words into current words
// - command register is read/write and cleared by reset or master clear
// - command bit 7 makes grants active high, bit 6 requests active low
// - command bit 5 starts write commands in s2 with read commands
// - command bit 4 selects rotating priority, otherwise fixed priority
// - command bit 3 selects compressed timing, otherwise normal timing
// - command bit 2 disables all dma cycles
// - bit 0 enables memory to memory on channels 0/1, bit 1 holds channel 0 address
// - mode writes share one address, data bits 1:0 pick the channel
// - mode bits 7:6 pick demand, single, block or cascade
// - mode bit 5 counts address down, bit 4 enables auto reload
// - mode bits 3:2 pick verify, write or read; 11 is illegal
// - mode reads return channels 0 to 3 in turn, bits 1:0 ones
// - request write sets or clears one software request, unmasked, reset clears
// - request read gives the four requests low, ones in bits 7:4
// - single mask write sets or clears one mask bit by bit 2
// - all mask location reads and writes four bits, set by clears and by terminal count without auto reload
// - status holds terminal count flags low, live pending requests high
// - temporary register keeps memory to memory data until reset or master clear
// - special commands act on address and strobe only, data ignored
// - master clear resets all but the mode, word and data bus output registers and leaves the sequencer idle
`timescale 1ns/10ps
module dma_channel_register_set (
	input wire logic clk_in,
	input wire logic rst_in,
	input wire logic [dma_regs_pkg::PORT_ADDR_W-1:0] port_addr_in,
	input wire logic io_read_strobe_in,
	input wire logic io_write_strobe_in,
	input wire logic [dma_regs_pkg::DATA_W-1:0] peripheral_data_bus_in,
	output logic [dma_regs_pkg::DATA_W-1:0] peripheral_data_bus_out,
	output logic peripheral_data_bus_oe_out,
	input wire logic [dma_regs_pkg::CHANNELS-1:0] channel_request_in,
	output logic [dma_regs_pkg::CHANNELS-1:0] channel_grant_out,
	output logic read_command_out,
	output logic write_command_out,
	output logic terminal_count_out,
	output logic [dma_regs_pkg::WORD_W-1:0] transfer_address_out
);
	import dma_regs_pkg::*;

	// one hot channel decode, shared by request, mask and grant logic
	function automatic logic [CHANNELS-1:0] sel_onehot(input logic [1:0] sel);
		sel_onehot = '0;
		sel_onehot[sel] = 1'b1;
	endfunction

	logic [7:0] controller_command;
	logic [7:2] channel_mode [CHANNELS];
	logic [CHANNELS-1:0] soft_request_state;
	logic [CHANNELS-1:0] channel_masks;
	logic [CHANNELS-1:0] terminal_count_flag;
	logic [CHANNELS-1:0] pending_request_flag;
	logic [7:0] temp_data;
	logic [1:0] mode_read_count;
	logic byte_pointer;
	logic clear_all;
	logic wr_word, rd_word;
	logic wr_cmd, rd_status, rd_cmd, wr_req, rd_req, wr_single, wr_mode, rd_mode;
	logic wr_clr_bp, rd_set_bp, wr_clr_mask, rd_clr_mode, wr_all, rd_all, rd_temp;
	logic [CHANNELS-1:0] req_active;
	logic [CHANNELS-1:0] pending;
	logic pick_valid;
	logic [1:0] pick_ch;
	cycle_state_t state;
	logic [1:0] chan;
	logic [1:0] last_served;
	logic mm_phase;
	logic [CHANNELS-1:0] grant_vec;
	logic [WORD_W-1:0] cur_address [CHANNELS];
	logic [WORD_W-1:0] cur_count [CHANNELS];
	logic [CHANNELS-1:0] ch_terminal;
	logic [CHANNELS-1:0] ch_step;
	logic mem_to_mem;
	logic step_now;
	logic tc_now;
	logic [1:0] cur_xfer;
	logic [1:0] cur_type;
	logic [CHANNELS-1:0] tc_set;
	logic [CHANNELS-1:0] mask_set;
	logic [CHANNELS-1:0] soft_clear;
	logic [7:0] next_read;

	// strobe decode of every port location
	assign wr_word = io_write_strobe_in && (port_addr_in <= ADDR_WORD_LAST);
	assign rd_word = io_read_strobe_in && (port_addr_in <= ADDR_WORD_LAST);
	assign wr_cmd = io_write_strobe_in && (port_addr_in == ADDR_COMMAND_STATUS);
	assign rd_status = io_read_strobe_in && (port_addr_in == ADDR_COMMAND_STATUS);
	assign wr_req = io_write_strobe_in && (port_addr_in == ADDR_REQUEST);
	assign rd_req = io_read_strobe_in && (port_addr_in == ADDR_REQUEST);
	assign wr_single = io_write_strobe_in && (port_addr_in == ADDR_SINGLE_MASK);
	assign rd_cmd = io_read_strobe_in && (port_addr_in == ADDR_SINGLE_MASK);
	assign wr_mode = io_write_strobe_in && (port_addr_in == ADDR_MODE);
	assign rd_mode = io_read_strobe_in && (port_addr_in == ADDR_MODE);
	assign wr_clr_bp = io_write_strobe_in && (port_addr_in == ADDR_BYTE_PTR);
	assign rd_set_bp = io_read_strobe_in && (port_addr_in == ADDR_BYTE_PTR);
	assign rd_temp = io_read_strobe_in && (port_addr_in == ADDR_MASTER_CLEAR);
	assign wr_clr_mask = io_write_strobe_in && (port_addr_in == ADDR_CLEAR_MASK);
	assign rd_clr_mode = io_read_strobe_in && (port_addr_in == ADDR_CLEAR_MASK);
	assign wr_all = io_write_strobe_in && (port_addr_in == ADDR_ALL_MASK);
	assign rd_all = io_read_strobe_in && (port_addr_in == ADDR_ALL_MASK);

	// master clear behaves as a reset of all but the mode, word and data bus output registers
	assign clear_all = rst_in ||
		(io_write_strobe_in && (port_addr_in == ADDR_MASTER_CLEAR));

	// request polarity and arbitration inputs
	assign req_active = controller_command[CMD_REQ_POL] ? ~channel_request_in
		: channel_request_in;
	assign pending = (req_active & ~channel_masks) | soft_request_state;
	assign mem_to_mem = controller_command[CMD_MEM_TO_MEM];
	assign cur_xfer = channel_mode[chan][MODE_XFER_HI:MODE_XFER_LO];
	assign cur_type = channel_mode[chan][MODE_TYPE_HI:MODE_TYPE_LO];

	priority_pick arbiter (
		.pending_in(pending),
		.rotate_in(controller_command[CMD_ROTATE]),
		.last_in(last_served),
		.valid_out(pick_valid),
		.winner_out(pick_ch)
	);

	// the transfer step happens at the end of s4
	assign step_now = (state == st_s4);
	assign ch_step = step_now ? sel_onehot(chan) : '0;
	assign tc_now = step_now && ch_terminal[chan];

	// per channel word registers
	generate
		for (genvar c = 0; c < CHANNELS; c++) begin : g_chan
			channel_word_regs words (
				.clk_in(clk_in),
				.rst_in(rst_in),
				.write_in(wr_word && (port_addr_in[WORD_CH_HI:WORD_CH_LO] == 2'(c))),
				.count_sel_in(port_addr_in[WORD_SEL_BIT]),
				.high_byte_in(byte_pointer),
				.data_in(peripheral_data_bus_in),
				.step_in(ch_step[c]),
				.count_down_in(channel_mode[c][MODE_DEC]),
				.hold_in(c == 0 && mem_to_mem && controller_command[CMD_ADDR_HOLD]),
				.reload_in(channel_mode[c][MODE_AUTO]),
				.address_out(cur_address[c]),
				.count_out(cur_count[c]),
				.terminal_out(ch_terminal[c])
			);
		end
	endgenerate

	// command register
	always_ff @(posedge clk_in) begin
		if (clear_all)
			controller_command <= COMMAND_RESET;
		else if (wr_cmd)
			controller_command <= peripheral_data_bus_in;
	end

	// mode registers share one write address
	always_ff @(posedge clk_in) begin
		if (rst_in) begin
			for (int c = 0; c < CHANNELS; c++)
				channel_mode[c] <= '0;
		end else if (wr_mode) begin
			channel_mode[peripheral_data_bus_in[SEL_HI:SEL_LO]] <=
				peripheral_data_bus_in[7:2];
		end
	end

	// mode read counter walks channels 0 to 3
	always_ff @(posedge clk_in) begin
		if (clear_all || rd_clr_mode)
			mode_read_count <= 2'h0;
		else if (rd_mode)
			mode_read_count <= mode_read_count + 2'h1;
	end

	// byte pointer for the 16 bit words
	always_ff @(posedge clk_in) begin
		if (clear_all || wr_clr_bp)
			byte_pointer <= 1'b0;
		else if (rd_set_bp)
			byte_pointer <= 1'b1;
		else if (wr_word || rd_word)
			byte_pointer <= ~byte_pointer;
	end

	// event sets wins over cpu clears
	always_comb begin
		tc_set = tc_now ? sel_onehot(mm_phase ? 2'h1 : chan) : '0;
		mask_set = (tc_now && !channel_mode[chan][MODE_AUTO]) ? sel_onehot(chan) : '0;
		soft_clear = tc_now ? sel_onehot(mem_to_mem ? 2'h0 : chan) : '0;
	end

	// software requests
	always_ff @(posedge clk_in) begin
		if (clear_all)
			soft_request_state <= '0;
		else if (wr_req) begin
			if (peripheral_data_bus_in[VALUE_BIT])
				soft_request_state <= (soft_request_state & ~soft_clear) |
					sel_onehot(peripheral_data_bus_in[SEL_HI:SEL_LO]);
			else
				soft_request_state <= soft_request_state & ~soft_clear &
					~sel_onehot(peripheral_data_bus_in[SEL_HI:SEL_LO]);
		end else
			soft_request_state <= soft_request_state & ~soft_clear;
	end

	// request masks
	always_ff @(posedge clk_in) begin
		if (clear_all)
			channel_masks <= MASK_RESET;
		else if (wr_clr_mask)
			channel_masks <= mask_set;
		else if (wr_all)
			channel_masks <= peripheral_data_bus_in[3:0] | mask_set;
		else if (wr_single) begin
			if (peripheral_data_bus_in[VALUE_BIT])
				channel_masks <= channel_masks | mask_set |
					sel_onehot(peripheral_data_bus_in[SEL_HI:SEL_LO]);
			else
				channel_masks <= (channel_masks &
					~sel_onehot(peripheral_data_bus_in[SEL_HI:SEL_LO])) | mask_set;
		end else
			channel_masks <= channel_masks | mask_set;
	end

	// status flags
	always_ff @(posedge clk_in) begin
		if (clear_all) begin
			terminal_count_flag <= '0;
			pending_request_flag <= '0;
		end else begin
			terminal_count_flag <= (rd_status ? '0 : terminal_count_flag) | tc_set;
			pending_request_flag <= req_active;
		end
	end

	// temporary register loads on the read half of memory to memory
	always_ff @(posedge clk_in) begin
		if (clear_all)
			temp_data <= BYTE_ZERO;
		else if (step_now && mem_to_mem && !mm_phase)
			temp_data <= peripheral_data_bus_in;
	end

	// transfer sequencer
	always_ff @(posedge clk_in) begin
		if (clear_all) begin
			state <= st_idle;
			chan <= 2'h0;
			last_served <= SEL_READ_ONES;
			mm_phase <= 1'b0;
			grant_vec <= '0;
			terminal_count_out <= 1'b0;
		end else begin
			terminal_count_out <= tc_now;
			unique case (state)
				st_idle: begin
					mm_phase <= 1'b0;
					grant_vec <= '0;
					if (controller_command[CMD_DISABLE]) begin
						state <= st_idle;
					end else if (mem_to_mem && soft_request_state[0]) begin
						chan <= 2'h0;
						state <= st_s2;
					end else if (pick_valid) begin
						chan <= pick_ch;
						last_served <= pick_ch;
						grant_vec <= sel_onehot(pick_ch);
						state <= (channel_mode[pick_ch][MODE_XFER_HI:MODE_XFER_LO]
							== XFER_CASCADE) ? st_cascade : st_s2;
					end
				end
				st_s2: state <= st_s3;
				st_s3: begin
					if (controller_command[CMD_COMPRESSED] && !mem_to_mem)
						state <= st_s4;
					else
						state <= st_s3_wait;
				end
				st_s3_wait: state <= st_s4;
				st_s4: begin
					if (mem_to_mem && !mm_phase) begin
						mm_phase <= 1'b1;
						chan <= 2'h1;
						state <= st_s2;
					end else if (tc_now || mem_to_mem || controller_command[CMD_DISABLE]) begin
						state <= st_idle;
						grant_vec <= '0;
					end else if (cur_xfer == XFER_BLOCK ||
						(cur_xfer == XFER_DEMAND && req_active[chan])) begin
						state <= st_s2;
					end else begin
						state <= st_idle;
						grant_vec <= '0;
					end
				end
				st_cascade: begin
					if (!(req_active[chan] || soft_request_state[chan])) begin
						state <= st_idle;
						grant_vec <= '0;
					end
				end
			endcase
		end
	end

	// grant polarity
	assign channel_grant_out = controller_command[CMD_GRANT_POL] ? grant_vec
		: ~grant_vec;

	// transfer commands and address
	always_ff @(posedge clk_in) begin
		if (clear_all) begin
			read_command_out <= 1'b0;
			write_command_out <= 1'b0;
			transfer_address_out <= WORD_ZERO;
		end else begin
			transfer_address_out <= cur_address[chan];
			read_command_out <= 1'b0;
			write_command_out <= 1'b0;
			if (state == st_s2 || state == st_s3 || state == st_s3_wait) begin
				if (mem_to_mem)
					read_command_out <= !mm_phase;
				else
					read_command_out <= (cur_type != TYPE_VERIFY);
				if (state != st_s2 || controller_command[CMD_EARLY_WRITE] ||
					(controller_command[CMD_COMPRESSED] && !mem_to_mem)) begin
					if (mem_to_mem)
						write_command_out <= mm_phase;
					else
						write_command_out <= (cur_type != TYPE_VERIFY);
				end
			end
		end
	end

	// cpu read data
	always_comb begin
		next_read = BYTE_ZERO;
		if (rd_word)
			next_read = port_addr_in[WORD_SEL_BIT] ?
				(byte_pointer ? cur_count[port_addr_in[WORD_CH_HI:WORD_CH_LO]][15:8]
				: cur_count[port_addr_in[WORD_CH_HI:WORD_CH_LO]][7:0])
				: (byte_pointer ? cur_address[port_addr_in[WORD_CH_HI:WORD_CH_LO]][15:8]
				: cur_address[port_addr_in[WORD_CH_HI:WORD_CH_LO]][7:0]);
		else if (rd_status)
			next_read = {pending_request_flag, terminal_count_flag};
		else if (rd_cmd)
			next_read = controller_command;
		else if (rd_req)
			next_read = {UPPER_ONES, soft_request_state};
		else if (rd_mode)
			next_read = {channel_mode[mode_read_count], SEL_READ_ONES};
		else if (rd_all)
			next_read = {UPPER_ONES, channel_masks};
		else if (rd_temp)
			next_read = temp_data;
	end

	// data bus drive for cpu reads and memory to memory writes
	always_ff @(posedge clk_in) begin
		if (rst_in) begin
			peripheral_data_bus_out <= BYTE_ZERO;
			peripheral_data_bus_oe_out <= 1'b0;
		end else if (io_read_strobe_in) begin
			peripheral_data_bus_out <= next_read;
			peripheral_data_bus_oe_out <= 1'b1;
		end else if (mem_to_mem && mm_phase && (state == st_s3 || state == st_s3_wait ||
			(state == st_s2 && controller_command[CMD_EARLY_WRITE]))) begin
			peripheral_data_bus_out <= temp_data;
			peripheral_data_bus_oe_out <= 1'b1;
		end else begin
			peripheral_data_bus_out <= BYTE_ZERO;
			peripheral_data_bus_oe_out <= 1'b0;
		end
	end
endmodule // dma_channel_register_set

// file: verilog/priority_pick.sv
// fixed or rotating choice of one requesting channel
`timescale 1ns/10ps
module priority_pick (
	input wire logic [dma_regs_pkg::CHANNELS-1:0] pending_in,
	input wire logic rotate_in,
	input wire logic [1:0] last_in,
	output logic valid_out,
	output logic [1:0] winner_out
);
	import dma_regs_pkg::*;

	// scan from the highest priority slot downwards
	always_comb begin
		logic [1:0] idx;
		idx = 2'h0;
		valid_out = 1'b0;
		winner_out = 2'h0;
		for (int i = 0; i < CHANNELS; i++) begin
			idx = rotate_in ? 2'(last_in + 2'(i) + 2'h1) : 2'(i);
			if (!valid_out && pending_in[idx]) begin
				valid_out = 1'b1;
				winner_out = idx;
			end
		end
	end
endmodule // priority_pick
